/* core/afpm_pkg.sv */
// shared constants for the alternate-function pin multiplexer
package afpm_pkg;
  // ==========================================================
  // routing select field codes (hi, lo)
  localparam logic [1:0] AFPM_ROUTE_PORT = 2'h0;
  localparam logic [1:0] AFPM_ROUTE_OSC = 2'h1;
  localparam logic [1:0] AFPM_ROUTE_RST = 2'h2;
  // ==========================================================
  // register reset values and field positions
  localparam logic [7:0] AFPM_CLK_MODE_RST = 8'h00;
  localparam logic [7:0] AFPM_RST_MASK_RST = 8'h20;
  localparam int AFPM_RST_MASK_BIT = 5;
  localparam int AFPM_CLK_XTAL_BIT = 6;
  localparam int AFPM_CLK_EXT_BIT = 7;
  localparam logic [7:0] AFPM_ROUTE_RST_VAL = 8'h00;
  // ==========================================================
  // analog channel numbers on port 7
  localparam logic [3:0] AFPM_ANA_CH_FIRST = 4'h8;
  localparam logic [3:0] AFPM_ANA_CH_LAST = 4'hA;
endpackage

/* core/afpm_pin_cell.sv */
// one shared pin: peripheral output ANDed with latch, else latch alone, with drive type
`timescale 1ns/1ps
`default_nettype none
module afpm_pin_cell
  import afpm_pkg::*;
(
  input wire logic dir_in_i,     // direction bit, 1 = input
  input wire logic latch_i,      // output latch value
  input wire logic periph_en_i,  // peripheral output active
  input wire logic periph_i,     // peripheral output value
  input wire logic open_drain_i, // n-channel open-drain mode
  output logic pin_o,            // pin output value
  output logic pin_oe_o          // pin output enable
);
  logic level;
  always_comb
  begin
    level = periph_en_i ? (periph_i & latch_i) : latch_i;
    pin_o = level;
    pin_oe_o = !dir_in_i && (!open_drain_i || !level);
  end
endmodule
`default_nettype wire

/* core/afpm_pin_mux.sv */
// alternate-function pin multiplexer top
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module afpm_pin_mux
  import afpm_pkg::*;
#(
  parameter int P2_PINS = 8,    // port-2 analog pins
  parameter int P1_PINS = 3,    // port-1 analog pins
  parameter bit HAS_P7 = 1'b1   // 32-pin variant has port 7
)(
  input wire logic core_clk_i,            // system clock
  input wire logic reset_i,               // sync reset, active high
  input wire logic clk_en_i,              // clock enable
  input wire logic wr_en_i,               // config write strobe
  input wire logic [7:0] routing_select_i, // routing select data
  input wire logic [7:0] clock_mode_i,    // clock mode data
  input wire logic [7:0] reset_mask_i,    // reset mask data
  input wire logic [1:0] port6_drive_type_i, // 1 = open-drain per pin
  input wire logic [1:0] port6_input_type_i, // 1 = smbus buffer
  input wire logic [1:0] p6_dir_i,        // port-6 direction bits
  input wire logic [1:0] p6_latch_i,      // port-6 latch bits
  input wire logic uart_tx_en_i,          // uart transmit active
  input wire logic uart_tx_i,             // uart transmit value
  input wire logic twi_en_i,              // two-wire active
  input wire logic [1:0] twi_out_i,       // two-wire clock/data out
  input wire logic [1:0] p6_pin_i,        // port-6 pin levels
  input wire logic osc_pin_i,             // first oscillator pin level
  input wire logic rst_pin_i,             // reset pin level
  input wire logic port0_pin_i,           // port-0 pin 0 level
  input wire logic [7:0] analog_pin_select_a_i, // count of analog port-2 pins
  input wire logic [7:0] analog_pin_select_b_i, // analog pins on ports 1/7
  input wire logic [3:0] channel_select_i, // converter channel
  input wire logic [7:0] port2_direction_i, // port-2 direction
  input wire logic [7:0] port1_direction_i, // port-1 direction
  input wire logic [2:0] port7_direction_i, // port-7 direction
  input wire logic amp0_enable_i,         // amp0 enable
  input wire logic amp1_enable_i,         // amp1 enable
  input wire logic gain_input_i,          // gain input bit
  output logic [1:0] p6_pin_o,            // port-6 pin outputs
  output logic [1:0] p6_pin_oe_o,         // port-6 output enables
  output logic [1:0] p6_smbus_sel_o,      // smbus input buffer select
  output logic capture_input_0_o,         // routed capture input
  output logic ext_irq_0_o,               // routed external irq 0
  output logic ext_reset_en_o,            // reset pin acts as reset
  output logic osc_pins_port_o,           // oscillator pins are port pins
  output logic external_main_clock_sel_o, // external clock mode
  output logic xtal_sel_o,                // crystal mode
  output logic [7:0] p2_analog_o,         // port-2 analog connected
  output logic amp0_connect_o,            // amp0 pins connected
  output logic [2:0] p1_analog_o,         // port-1 analog connected
  output logic amp1_connect_o,            // amp1 pins connected
  output logic [2:0] analog_channels_8_10_o // port-7 analog connected
);
  // refuse pin counts the logic cannot serve; amp0 needs port-2 pins 0..2
  if (P2_PINS < 3 || P2_PINS > 8 || P1_PINS < 1 || P1_PINS > 3)
  begin : g_bad_counts
    $error("afpm_pin_mux: unsupported pin counts");
  end

  // ==========================================================
  // configuration registers
  logic [7:0] routing_select_reg, next_routing_select_reg;
  logic [7:0] clock_mode_reg, next_clock_mode_reg;
  logic [7:0] reset_mask_reg, next_reset_mask_reg;
  logic [1:0] capture_route, irq0_route;

  // next values of the config group
  always_comb
  begin
    next_routing_select_reg = routing_select_reg;
    next_clock_mode_reg = clock_mode_reg;
    next_reset_mask_reg = reset_mask_reg;
    if (wr_en_i)
    begin
      next_routing_select_reg = routing_select_i;
      next_clock_mode_reg = clock_mode_i;
      next_reset_mask_reg = reset_mask_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      routing_select_reg <= AFPM_ROUTE_RST_VAL;
      clock_mode_reg <= AFPM_CLK_MODE_RST;
      reset_mask_reg <= AFPM_RST_MASK_RST;
    end
    else if (clk_en_i)
    begin
      routing_select_reg <= next_routing_select_reg;
      clock_mode_reg <= next_clock_mode_reg;
      reset_mask_reg <= next_reset_mask_reg;
    end
  end

  // ==========================================================
  // capture and irq0 routing
  function automatic logic route_pick(input logic [1:0] sel, input logic port_v,
                                      input logic osc_v, input logic rst_v);
    case (sel)
      AFPM_ROUTE_OSC: route_pick = osc_v;
      AFPM_ROUTE_RST: route_pick = rst_v;
      default: route_pick = port_v;
    endcase
  endfunction

  assign capture_route = routing_select_reg[1:0]; // capture_route_hi, lo
  assign irq0_route = routing_select_reg[3:2];    // irq0_route_hi, lo
  always_comb
  begin
    capture_input_0_o = route_pick(capture_route, port0_pin_i, osc_pin_i, rst_pin_i);
    ext_irq_0_o = route_pick(irq0_route, port0_pin_i, osc_pin_i, rst_pin_i);
  end

  // reset pin active when mask bit clear
  assign ext_reset_en_o = !reset_mask_reg[AFPM_RST_MASK_BIT];
  assign xtal_sel_o = clock_mode_reg[AFPM_CLK_XTAL_BIT];
  assign external_main_clock_sel_o = clock_mode_reg[AFPM_CLK_EXT_BIT];
  assign osc_pins_port_o = !(xtal_sel_o || external_main_clock_sel_o);

  // ==========================================================
  // port-6 pins: clock/tx on pin 0, data on pin 1
  logic [1:0] p6_en, p6_val;
  always_comb
  begin
    p6_en[0] = twi_en_i || uart_tx_en_i;
    p6_val[0] = twi_en_i ? twi_out_i[0] : uart_tx_i;
    p6_en[1] = twi_en_i;
    p6_val[1] = twi_out_i[1];
  end

  for (genvar i = 0; i < 2; i++)
  begin : g_p6
    afpm_pin_cell u_cell (
      .dir_in_i(p6_dir_i[i]),
      .latch_i(p6_latch_i[i]),
      .periph_en_i(p6_en[i]),
      .periph_i(p6_val[i]),
      .open_drain_i(port6_drive_type_i[i]),
      .pin_o(p6_pin_o[i]),
      .pin_oe_o(p6_pin_oe_o[i])
    );
  end

  assign p6_smbus_sel_o = port6_input_type_i;

  // ==========================================================
  // port-2 analog and amp0
  always_comb
  begin
    p2_analog_o = '0;
    for (int i = 0; i < P2_PINS; i++)
      p2_analog_o[i] = (analog_pin_select_a_i > 8'(i)) && port2_direction_i[i];
    // converter must not sample the amplifier's own pins
    amp0_connect_o = amp0_enable_i && (&p2_analog_o[2:0]) && gain_input_i
                     && (channel_select_i > 4'h2);
  end

  always_comb
  begin
    p1_analog_o = '0;
    for (int i = 0; i < P1_PINS; i++)
      p1_analog_o[i] = analog_pin_select_b_i[i] && port1_direction_i[i];
    amp1_connect_o = amp1_enable_i && (&p1_analog_o);
  end

  always_comb
  begin
    analog_channels_8_10_o = '0;
    for (int i = 0; i < 3; i++)
      analog_channels_8_10_o[i] = HAS_P7 && analog_pin_select_b_i[i]
        && port7_direction_i[i] && (channel_select_i == AFPM_ANA_CH_FIRST + 4'(i));
  end

  // ==========================================================
  // assertions
  a_capture_osc_route: assert property (@(posedge core_clk_i) disable iff (reset_i)
    capture_route == AFPM_ROUTE_OSC |-> capture_input_0_o == osc_pin_i)
    else $error("capture not on oscillator pin");
  a_irq_rst_route: assert property (@(posedge core_clk_i) disable iff (reset_i)
    irq0_route == AFPM_ROUTE_RST |-> ext_irq_0_o == rst_pin_i)
    else $error("irq0 not on reset pin");
  a_clock_mode_reset: assert property (@(posedge core_clk_i)
    $past(reset_i) |-> osc_pins_port_o)
    else $error("oscillator pins not port after reset");
  a_smbus_sel_follow: assert property (@(posedge core_clk_i) disable iff (reset_i)
    p6_smbus_sel_o == port6_input_type_i)
    else $error("smbus select wrong");
  a_p7_channel_sel: assert property (@(posedge core_clk_i) disable iff (reset_i)
    analog_channels_8_10_o[0] |-> channel_select_i == AFPM_ANA_CH_FIRST)
    else $error("port-7 channel mismatch");
  a_p2_dir_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !port2_direction_i[0] |-> !p2_analog_o[0])
    else $error("port-2 analog with output direction");
  a_p1_amp_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    amp1_connect_o |-> amp1_enable_i && p1_analog_o[0])
    else $error("amp1 without enable");
  a_latch_drive: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !p6_dir_i[1] && !twi_en_i && !port6_drive_type_i[1]
    |-> p6_pin_oe_o[1] && p6_pin_o[1] == p6_latch_i[1])
    else $error("latch not driven");
  c_route_osc: cover property (@(posedge core_clk_i) capture_route == AFPM_ROUTE_OSC);
  c_route_rst: cover property (@(posedge core_clk_i) irq0_route == AFPM_ROUTE_RST);
  c_twi_drive: cover property (@(posedge core_clk_i) twi_en_i && p6_pin_oe_o[0]);
  c_amp0_on: cover property (@(posedge core_clk_i) amp0_connect_o);
endmodule
`default_nettype wire

/* tb/afpm_periph_model.sv */
// behavioural model of the serial peripherals that share port 6
`timescale 1ns/1ps
`default_nettype none
module afpm_periph_model (
  input wire logic core_clk_i,   // system clock
  input wire logic uart_on_i,    // uart running
  input wire logic twi_on_i,     // two-wire running
  output logic uart_tx_en_o,     // uart transmit active
  output logic uart_tx_o,        // uart transmit value
  output logic twi_en_o,         // two-wire active
  output logic [1:0] twi_out_o   // two-wire clock and data
);
  // ==========================================================
  // phase counter gives changing line values every cycle
  logic [1:0] phase = 2'h0;
  always @(posedge core_clk_i)
  begin
    #1;
    phase = phase + 2'h1;
  end
  // lines idle high when the peripheral is off
  assign uart_tx_en_o = uart_on_i;
  assign uart_tx_o = uart_on_i ? phase[0] : 1'b1;
  assign twi_en_o = twi_on_i;
  assign twi_out_o = twi_on_i ? phase : 2'h3;
endmodule
`default_nettype wire

/* tb/alt_function_pin_mux_test.sv */
// self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module alt_function_pin_mux_test;
  import afpm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic we = 1'b0;
  logic [7:0] rsel = 8'h00, cmode = 8'h00, rmask = 8'h20, ana = 8'h00;
  logic [7:0] selb = 8'h00, p2d = 8'h00, p1d = 8'h00, p2an;
  logic [2:0] p7d = 3'h0, p1an, p7an;
  logic a0 = 1'b0, a1 = 1'b0, amp0c, amp1c;
  logic [1:0] drv = 2'h0, ityp = 2'h0, dir = 2'h3, lat = 2'h0, p6in = 2'h0;
  logic osc = 1'b0, rpin = 1'b0, p0 = 1'b0, uon = 1'b0, ton = 1'b0, gain = 1'b0;
  logic [3:0] ch = 4'h0;
  logic utx_en, utx, twen, cap, irq, rst_en, oscp, exsel, xsel;
  logic [1:0] twout, pout, poe, smb;
  int fails = 0;
  int samples_checked = 0;
  // ==========================================================
  // clock, partner and design
  always #4 clk = ~clk;
  afpm_periph_model PEER (.core_clk_i(clk), .uart_on_i(uon), .twi_on_i(ton),
    .uart_tx_en_o(utx_en), .uart_tx_o(utx), .twi_en_o(twen), .twi_out_o(twout));
  afpm_pin_mux DUT (.core_clk_i(clk), .reset_i(rst), .clk_en_i(ce), .wr_en_i(we),
    .routing_select_i(rsel), .clock_mode_i(cmode), .reset_mask_i(rmask),
    .port6_drive_type_i(drv), .port6_input_type_i(ityp), .p6_dir_i(dir),
    .p6_latch_i(lat), .uart_tx_en_i(utx_en), .uart_tx_i(utx), .twi_en_i(twen),
    .twi_out_i(twout), .p6_pin_i(p6in), .osc_pin_i(osc), .rst_pin_i(rpin),
    .port0_pin_i(p0), .analog_pin_select_a_i(ana), .analog_pin_select_b_i(selb),
    .channel_select_i(ch), .port2_direction_i(p2d), .port1_direction_i(p1d),
    .port7_direction_i(p7d), .amp0_enable_i(a0), .amp1_enable_i(a1),
    .gain_input_i(gain), .p6_pin_o(pout), .p6_pin_oe_o(poe), .p6_smbus_sel_o(smb),
    .capture_input_0_o(cap), .ext_irq_0_o(irq), .ext_reset_en_o(rst_en),
    .osc_pins_port_o(oscp), .external_main_clock_sel_o(exsel), .xtal_sel_o(xsel),
    .p2_analog_o(p2an), .amp0_connect_o(amp0c), .p1_analog_o(p1an), .amp1_connect_o(amp1c),
    .analog_channels_8_10_o(p7an));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] c, input logic [7:0] m);
    @(posedge clk);
    #1;
    we = 1'b1;
    rsel = r;
    cmode = c;
    rmask = m;
    repeat (2) @(posedge clk);
    #1;
    we = 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    #2;
    chk(oscp, 8'h01, "osc pins port");
    chk({xsel, exsel}, 8'h00, "clock mode");
    chk(rst_en, 8'h00, "reset pin masked");
    $display("reset test done");
  endtask
  task automatic test_route();
    logic [1:0] c;
    for (int k = 0; k < 4; k++)
    begin
      c = k[1:0];
      wr({4'h0, c, c}, 8'h00, 8'h20);
      for (int s = 0; s < 3; s++)
      begin
        @(posedge clk);
        #1;
        osc = (s == 0);
        rpin = (s == 1);
        p0 = (s == 2);
        #2;
        chk(cap, (c == AFPM_ROUTE_OSC) ? osc : (c == AFPM_ROUTE_RST) ? rpin : p0, "cap");
        chk(irq, (c == AFPM_ROUTE_OSC) ? osc : (c == AFPM_ROUTE_RST) ? rpin : p0, "irq");
      end
    end
    $display("route test done");
  endtask
  task automatic test_regs();
    wr(8'h00, 8'h40, 8'h20);
    chk({oscp, exsel, xsel}, 8'h01, "crystal mode");
    wr(8'h00, 8'h80, 8'h00);
    chk({oscp, exsel, xsel, rst_en}, 8'h05, "ext clock, reset on");
    ce = 1'b0;
    wr(8'h00, 8'h00, 8'h20);
    chk({exsel, rst_en}, 8'h03, "write without enable");
    ce = 1'b1;
    $display("register test done");
  endtask
  task automatic p6_look(input logic [1:0] d, input logic [1:0] l, input logic [1:0] od);
    @(posedge clk);
    #1;
    drv = od;
    dir = d;
    lat = l;
    repeat (4)
    begin
      @(posedge clk);
      #3;
      if (d == 2'h3)
        chk(poe, 8'h00, "input pins float");
      else if (od != 2'h0)
        chk(poe, {6'h00, ~twout}, "open drain enable");
      else if (ton)
        chk({poe, pout}, {2'h3, twout & l}, "two-wire push-pull");
      else
        chk({poe[0], pout[0]}, {1'b1, utx & l[0]}, "uart push-pull");
    end
  endtask
  task automatic test_p6();
    @(posedge clk);
    #1;
    ton = 1'b1;
    // output functions: direction 0, serial latch 1
    p6_look(2'h0, 2'h3, 2'h0);
    p6_look(2'h0, 2'h0, 2'h0);
    p6_look(2'h0, 2'h3, 2'h3);
    p6_look(2'h3, 2'h3, 2'h0);
    @(posedge clk);
    #1;
    ityp = 2'h2;
    ton = 1'b0;
    uon = 1'b1;
    #2;
    chk(smb, 8'h02, "smbus buffer");
    p6_look(2'h2, 2'h3, 2'h0);
    uon = 1'b0;
    $display("port 6 test done");
  endtask
  task automatic test_analog();
    // first three port-2 pins analog, amp0 on
    @(posedge clk);
    #1;
    ana = 8'h03;
    p2d = 8'hFF;
    gain = 1'b1;
    a0 = 1'b1;
    ch = 4'h4;
    #2;
    chk(p2an, 8'h07, "port-2 analog count");
    chk(amp0c, 8'h01, "amp0 connected");
    @(posedge clk);
    #1;
    p2d = 8'hFE;
    #2;
    chk(p2an, 8'h06, "port-2 output pin kept");
    chk(amp0c, 8'h00, "amp0 needs its pins");
    @(posedge clk);
    #1;
    p2d = 8'hFF;
    ch = 4'h1;
    #2;
    chk(amp0c, 8'h00, "amp0 with converter on its pins");
    @(posedge clk);
    #1;
    gain = 1'b0;
    ch = 4'h4;
    #2;
    chk(amp0c, 8'h00, "amp0 without gain input");
    @(posedge clk);
    #1;
    selb = 8'h07;
    p1d = 8'h07;
    a1 = 1'b1;
    #2;
    chk(p1an, 8'h07, "port-1 analog pins");
    chk(amp1c, 8'h01, "amp1 connected");
    @(posedge clk);
    #1;
    p1d = 8'h05;
    #2;
    chk(p1an, 8'h05, "port-1 output pin kept");
    chk(amp1c, 8'h00, "amp1 needs all pins");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      #1;
      p7d = 3'h7;
      ch = AFPM_ANA_CH_FIRST + 4'(k);
      #2;
      chk(p7an, (ch <= AFPM_ANA_CH_LAST) ? 8'h01 << k : 8'h00, "port-7 channel");
    end
    @(posedge clk);
    #1;
    p7d = 3'h6;
    ch = AFPM_ANA_CH_FIRST;
    #2;
    chk(p7an, 8'h00, "port-7 pin as output");
    $display("analog test done");
  endtask
  // ==========================================================
  // verdict and sequence
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    do_reset();
    test_route();
    test_regs();
    do_reset();
    test_p6();
    test_analog();
    end_of_test();
  end
endmodule
`default_nettype wire
